// File: core/iop_bus_pkg.sv
// constants and carrier types for the i/o processor bus arbiter
// assumes one 40 MHz clock and a synchronous active-high reset
package iop_bus_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 25;
    localparam int SYNC_PERIOD_NS = 1000;
    localparam int SYNC_WIDTH_NS  = 250;
    localparam int GRANT_DELAY_NS = 1000;
    localparam int GRANT_WIDTH_NS = 250;
    localparam int GAP_NS         = 250;
    localparam int SYNC_PERIOD_CYC = SYNC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SYNC_WIDTH_CYC  = SYNC_WIDTH_NS / CLK_PERIOD_NS;
    localparam int GRANT_DELAY_CYC = (GRANT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GRANT_WIDTH_CYC = (GRANT_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC         = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // sizes and carriers
    // ------------------------------------------------------------
    localparam int NUM_SLOTS = 8;
    localparam int ADDR_W    = 15;
    localparam int DATA_W    = 18;
    localparam int FIFO_DEPTH = 32;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } xfer_t;
    typedef enum logic [1:0] {ARB_IDLE, ARB_WAIT, ARB_GRANT, ARB_GAP} arb_state_t;
    typedef enum logic [1:0] {MEM_IDLE, MEM_REQ, MEM_REL} mem_state_t;
endpackage

// File: core/word_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes single clock, sync reset, clock enable freezing state
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 32
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wrPtr_q;
    logic [PW:0]      rdPtr_q;
    logic             push;
    logic             pop;
    assign inReady  = (wrPtr_q - rdPtr_q) != (PW+1)'(DEPTH);
    assign outValid = wrPtr_q != rdPtr_q;
    assign outData  = mem[rdPtr_q[PW-1:0]];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wrPtr_q <= '0;
        end else if (clkEn && push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdPtr_q <= '0;
        end else if (clkEn && pop) begin
            rdPtr_q <= rdPtr_q + 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (clkEn && push) begin
            mem[wrPtr_q[PW-1:0]] <= inData;
        end
    end
endmodule

// File: core/iop_bus_arbiter.sv
// i/o processor end of the chained request bus, single cycle input
// assumes devices keep the chain protocol; memory answers with ack
`timescale 1ns/1ps
module iop_bus_arbiter
    import iop_bus_pkg::*;
#(
    parameter int SLOTS = NUM_SLOTS,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              clkEn,
    input  wire logic [SLOTS-1:0]  devReq,
    input  wire logic              singleCycle,
    input  wire logic [ADDR_W-1:0] busAddr,
    input  wire logic [DATA_W-1:0] busData,
    input  wire logic              memAddrAck,
    output logic                   chainEnOut,
    output logic                   busSync,
    output logic                   grant,
    output logic [2:0]             activeSlot,
    output logic                   memWriteReq,
    output logic [ADDR_W-1:0]      memAddr,
    output logic [DATA_W-1:0]      memory_data_lines,
    output logic                   memory_release
);
    // ------------------------------------------------------------
    // bus sync generator
    // ------------------------------------------------------------
    logic [5:0] syncCnt_q;
    logic       b2b_q;
    logic       syncStart;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            syncCnt_q <= '0;
        end else if (clkEn) begin
            syncCnt_q <= (syncCnt_q == 6'(SYNC_PERIOD_CYC - 1)) ? '0 : syncCnt_q + 1'b1;
        end
    end
    // withheld while a device streams words back to back
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            busSync <= 1'b0;
        end else if (clkEn) begin
            // decided once per period so a burst ending mid-period cannot cut a pulse short
            if (syncCnt_q == '0) begin
                busSync <= !b2b_q;
            end else if (syncCnt_q == 6'(SYNC_WIDTH_CYC)) begin
                busSync <= 1'b0;
            end
        end
    end
    assign syncStart = (syncCnt_q == '0) && !b2b_q;
    assign chainEnOut = !sys_rst;
    // ------------------------------------------------------------
    // priority: lowest slot is nearest the processor
    // ------------------------------------------------------------
    logic [SLOTS-1:0] blocked;
    logic [2:0]       winIdx;
    logic             anyReq;
    assign blocked[0] = 1'b0;
    generate
        for (genvar i = 1; i < SLOTS; i++) begin : g_chain
            assign blocked[i] = blocked[i-1] | devReq[i-1];
        end
    endgenerate
    always_comb begin
        winIdx = '0;
        for (int k = SLOTS - 1; k >= 0; k--) begin
            if (devReq[k] && !blocked[k]) begin
                winIdx = 3'(k);
            end
        end
    end
    assign anyReq = |devReq;
    // ------------------------------------------------------------
    // grant sequencer
    // ------------------------------------------------------------
    arb_state_t arb_q;
    logic [5:0] tmr_q;
    logic       tmrDone;
    logic       wantIn;
    logic       holdReq;
    logic       strobe;
    logic       pushReady;
    xfer_t      pushWord;
    assign tmrDone = tmr_q == '0;
    assign wantIn  = anyReq && singleCycle;
    assign holdReq = devReq[activeSlot];
    assign strobe  = clkEn && arb_q == ARB_GRANT && tmrDone;
    assign grant   = arb_q == ARB_GRANT;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            arb_q <= ARB_IDLE;
            tmr_q <= '0;
        end else if (clkEn) begin
            if (!tmrDone) begin
                tmr_q <= tmr_q - 1'b1;
            end
            case (arb_q)
                ARB_IDLE: begin
                    if (syncStart) begin
                        arb_q <= ARB_WAIT;
                        tmr_q <= 6'(GRANT_DELAY_CYC - 1);
                    end
                end
                ARB_WAIT: begin
                    if (tmrDone) begin
                        // a full buffer holds grant off until memory drains
                        if (wantIn && pushReady) begin
                            arb_q <= ARB_GRANT;
                            tmr_q <= 6'(GRANT_WIDTH_CYC - 1);
                        end else if (syncStart) begin
                            // next sync lands on this edge; rearm so no period is skipped
                            tmr_q <= 6'(GRANT_DELAY_CYC - 1);
                        end else begin
                            arb_q <= ARB_IDLE;
                        end
                    end
                end
                ARB_GRANT: begin
                    if (tmrDone) begin
                        arb_q <= holdReq ? ARB_GAP : ARB_IDLE;
                        tmr_q <= 6'(GAP_CYC - 1);
                    end
                end
                ARB_GAP: begin
                    if (tmrDone && pushReady) begin
                        arb_q <= ARB_GRANT;
                        tmr_q <= 6'(GRANT_WIDTH_CYC - 1);
                    end
                end
                default: begin
                    arb_q <= ARB_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            b2b_q <= 1'b0;
        end else if (clkEn && strobe) begin
            b2b_q <= holdReq;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            activeSlot <= '0;
        end else if (clkEn && arb_q == ARB_WAIT && tmrDone) begin
            activeSlot <= winIdx;
        end
    end
    assign pushWord.addr = busAddr;
    assign pushWord.data = busData;
    // ------------------------------------------------------------
    // i/o buffer queue
    // ------------------------------------------------------------
    xfer_t popWord;
    logic  popValid;
    logic  popReady;
    word_fifo #(
        .WIDTH ($bits(xfer_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .inData   (pushWord),
        .inValid  (strobe),
        .inReady  (pushReady),
        .outData  (popWord),
        .outValid (popValid),
        .outReady (popReady)
    );
    // ------------------------------------------------------------
    // memory write handshake
    // ------------------------------------------------------------
    mem_state_t mem_q;
    assign popReady = clkEn && mem_q == MEM_REQ && memAddrAck;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mem_q <= MEM_IDLE;
        end else if (clkEn) begin
            case (mem_q)
                MEM_IDLE: mem_q <= popValid ? MEM_REQ : MEM_IDLE;
                MEM_REQ:  mem_q <= memAddrAck ? MEM_REL : MEM_REQ;
                MEM_REL:  mem_q <= MEM_IDLE;
                default:  mem_q <= MEM_IDLE;
            endcase
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            memWriteReq <= 1'b0;
            memory_release <= 1'b0;
        end else if (clkEn) begin
            memWriteReq <= (mem_q == MEM_IDLE && popValid)
                         || (mem_q == MEM_REQ && !memAddrAck);
            memory_release <= mem_q == MEM_REQ && memAddrAck;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            memAddr <= '0;
            memory_data_lines <= '0;
        end else if (clkEn) begin
            if (mem_q == MEM_IDLE && popValid) begin
                memAddr <= popWord.addr;
            end
            if (popReady) begin
                memory_data_lines <= popWord.data;
            end
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_ack;
        mem_q == MEM_REQ && memAddrAck && clkEn;
    endsequence
    sequence s_release;
        memory_release && !memWriteReq;
    endsequence
    property p_release;
        @(posedge clock) disable iff (sys_rst) s_ack |=> s_release;
    endproperty
    a_release: assert property (p_release) else $error("no release after ack");
    property p_mdl;
        @(posedge clock) disable iff (sys_rst)
            s_ack |=> memory_data_lines == $past(popWord.data);
    endproperty
    a_mdl: assert property (p_mdl) else $error("data lines wrong");
    property p_sync_width;
        @(posedge clock) disable iff (sys_rst)
            $rose(busSync) && clkEn |-> busSync[*8];
    endproperty
    a_sync_width: assert property (p_sync_width) else $error("sync too short");
    property p_sync_end;
        @(posedge clock) disable iff (sys_rst)
            $rose(busSync) |-> ##10 !busSync;
    endproperty
    a_sync_end: assert property (p_sync_end) else $error("sync too long");
    property p_sync_held;
        @(posedge clock) disable iff (sys_rst) b2b_q |=> !busSync;
    endproperty
    a_sync_held: assert property (p_sync_held) else $error("sync during burst");
    property p_grant_delay;
        @(posedge clock) disable iff (sys_rst)
            $rose(grant) && $past(arb_q) == ARB_WAIT |-> $past(syncStart, GRANT_DELAY_CYC + 1);
    endproperty
    a_grant_delay: assert property (p_grant_delay) else $error("grant early");
    property p_grant_width;
        @(posedge clock) disable iff (sys_rst)
            $rose(grant) |-> grant[*8] ##1 grant[*2] ##1 !grant;
    endproperty
    a_grant_width: assert property (p_grant_width) else $error("grant width wrong");
    property p_gap;
        @(posedge clock) disable iff (sys_rst)
            $fell(grant) && arb_q == ARB_GAP |-> !grant[*8] ##1 !grant[*2];
    endproperty
    a_gap: assert property (p_gap) else $error("regrant too soon");
    property p_b2b;
        @(posedge clock) disable iff (sys_rst)
            strobe && holdReq |=> arb_q == ARB_GAP;
    endproperty
    a_b2b: assert property (p_b2b) else $error("no back-to-back");
    property p_end;
        @(posedge clock) disable iff (sys_rst)
            strobe && !holdReq |=> arb_q == ARB_IDLE && !grant;
    endproperty
    a_end: assert property (p_end) else $error("cycle not ended");
    property p_slot;
        @(posedge clock) disable iff (sys_rst)
            devReq[0] && arb_q == ARB_WAIT && tmrDone && clkEn |=> activeSlot == 3'h0;
    endproperty
    a_slot: assert property (p_slot) else $error("nearest slot lost");
    property p_capture;
        @(posedge clock) disable iff (sys_rst)
            strobe |-> pushReady;
    endproperty
    a_capture: assert property (p_capture) else $error("captured word lost");
    property p_req_hold;
        @(posedge clock) disable iff (sys_rst)
            memWriteReq && !memAddrAck && clkEn |=> memWriteReq && $stable(memAddr);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("write request dropped");
    property p_rel_pulse;
        @(posedge clock) disable iff (sys_rst)
            memory_release |=> !memory_release;
    endproperty
    a_rel_pulse: assert property (p_rel_pulse) else $error("release too long");
endmodule

// File: tb/io_device_chain.sv
// model of the eight chained peripheral controllers on the bus
// assumes words[i] is the running count of words slot i should send
`timescale 1ns/1ps
module io_device_chain import iop_bus_pkg::*; (
    input  wire logic                        clock,
    input  wire logic                        sys_rst,
    input  wire logic                        chainEnIn,
    input  wire logic                        busSync,
    input  wire logic                        grant,
    input  wire logic [NUM_SLOTS-1:0][5:0]   words,
    output logic      [NUM_SLOTS-1:0]        devReq,
    output logic                             singleCycle,
    output logic      [ADDR_W-1:0]           busAddr,
    output logic      [DATA_W-1:0]           busData
);
    logic [NUM_SLOTS-1:0]      enIn;
    logic [NUM_SLOTS-1:0]      gateQ;
    logic [NUM_SLOTS-1:0]      dataPhaseFlop;
    logic [NUM_SLOTS-1:0][5:0] gateAge;
    logic [NUM_SLOTS-1:0][5:0] sentQ;
    logic                      syncQ;
    logic                      grantQ;
    logic [ADDR_W-1:0]         lastAddr;
    logic [DATA_W-1:0]         lastData;
    // ----
    // chain and bus lines
    // ----
    assign singleCycle = |devReq;
    always_comb begin
        enIn[0] = chainEnIn;
        for (int i = 1; i < NUM_SLOTS; i++) enIn[i] = enIn[i-1] & ~devReq[i-1] & ~gateQ[i-1];
    end
    // released lines flip every cycle, no stale word
    always_comb begin
        busAddr = ~lastAddr;
        busData = ~lastData;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (gateQ[i]) begin
                busAddr = {3'(i), 12'(sentQ[i])};
                busData = {3'(i), 15'(sentQ[i])} ^ 18'h2AAAA;
            end
        end
    end
    always_ff @(posedge clock) begin
        syncQ    <= busSync;
        grantQ   <= grant;
        lastAddr <= busAddr;
        lastData <= busData;
    end
    // ----
    // request and gate flops
    // ----
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            devReq <= '0;
            gateQ  <= '0;
            sentQ  <= '0;
            dataPhaseFlop <= '0;
            gateAge <= '0;
        end else begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                if (!enIn[i]) begin
                    devReq[i] <= 1'b0;
                end else if (busSync && !syncQ && sentQ[i] != words[i]) begin
                    devReq[i] <= 1'b1;
                end
                if (grant && !grantQ) begin
                    gateQ[i] <= devReq[i];
                    if (devReq[i] && sentQ[i] + 6'd1 == words[i]) devReq[i] <= 1'b0;
                end
                if (!grant && grantQ && gateQ[i]) begin
                    sentQ[i] <= sentQ[i] + 6'd1;
                    if (!devReq[i]) gateQ[i] <= 1'b0;
                end
                // data phase follows the address gate by one sync period
                if (!gateQ[i]) begin
                    gateAge[i] <= 6'h00;
                end else if (gateAge[i] != 6'(SYNC_PERIOD_CYC - 1)) begin
                    gateAge[i] <= gateAge[i] + 6'h01;
                end
                dataPhaseFlop[i] <= gateQ[i] && gateAge[i] == 6'(SYNC_PERIOD_CYC - 1);
            end
        end
    end
endmodule

// File: tb/io_bus_daisy_priority_single_cycle_in_tb_top.sv
// bench: arbiter against the device chain model and a memory responder
// assumes package, fifo, arbiter and chain model compiled first
`timescale 1ns/1ps
module io_bus_daisy_priority_single_cycle_in_tb_top import iop_bus_pkg::*;;
    logic                      clock, sys_rst, memAddrAck, chainEnOut, busSync, grant;
    logic                      memWriteReq, memory_release, singleCycle, ackHold;
    bit                        syncQ, grantQ, gapQ, reqQ;
    logic [2:0]                grantSlots[$];
    logic [NUM_SLOTS-1:0]      devReq;
    logic [NUM_SLOTS-1:0][5:0] words;
    logic [2:0]                activeSlot;
    logic [ADDR_W-1:0]         busAddr, memAddr;
    logic [DATA_W-1:0]         busData, memory_data_lines;
    xfer_t                     expQ[$];
    int miscompares, tests_run, cyc, syncCyc, syncToGrant, grantCnt, syncInBurst;
    int ackWait, ackCnt, reqCyc, reqToGrant;

    iop_bus_arbiter i_dut (.clock, .sys_rst, .clkEn(1'b1), .devReq, .singleCycle, .busAddr,
        .busData, .memAddrAck, .chainEnOut, .busSync, .grant, .activeSlot, .memWriteReq,
        .memAddr, .memory_data_lines, .memory_release);
    io_device_chain i_dev (.clock, .sys_rst, .chainEnIn(chainEnOut), .busSync, .grant,
        .words, .devReq, .singleCycle, .busAddr, .busData);

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ----
    // monitors and memory side
    // ----
    // outputs read on the falling edge, settled since the rising one
    always @(negedge clock) begin
        cyc++;
        if (|devReq && !reqQ) reqCyc = cyc;
        if (grant && !grantQ) begin
            grantCnt++;
            grantSlots.push_back(activeSlot);
            if (!gapQ) begin
                syncToGrant = cyc - syncCyc;
                reqToGrant = cyc - reqCyc;
            end
            gapQ = 1'b0;
        end
        if (busSync && !syncQ) begin
            if (gapQ) syncInBurst++;
            syncCyc = cyc;
        end
        if (!grant && grantQ) gapQ = |devReq;
        if (memory_release === 1'b1) begin
            if (expQ.size() == 0) chk_v("spare write", 0, 1);
            else chk_x("memory word", expQ.pop_front(), {memAddr, memory_data_lines});
        end
        syncQ = busSync;
        grantQ = grant;
        reqQ = |devReq;
    end
    // ack held off while stalled, memory may be slow
    always @(negedge clock) begin
        ackCnt = memWriteReq ? ackCnt + 1 : 0;
        memAddrAck <= memWriteReq && !ackHold && ackCnt > ackWait;
    end
    // ----
    // helpers
    // ----
    task automatic chk_v(string nm, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic chk_x(string nm, xfer_t e, xfer_t g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic push(int s, int k);
        for (int n = 0; n < k; n++) expQ.push_back({3'(s), 12'(n), {3'(s), 15'(n)} ^ 18'h2AAAA});
    endtask
    task automatic drain();
        for (int i = 0; i < 20000 && expQ.size() != 0; i++) @(posedge clock);
        chk_v("words left", 0, 16'(expQ.size()));
        repeat (100) @(negedge clock);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_single();
        @(negedge clock) words[5] = 6'd1;
        push(5, 1);
        drain();
        chk_v("sync to grant", 16'd40, 16'(syncToGrant));
        chk_v("request to grant", 16'(GRANT_DELAY_CYC - 1), 16'(reqToGrant));
    endtask
    task automatic t_priority();
        grantSlots.delete();
        @(negedge clock) begin
            words[0] = 6'd1;
            words[6] = 6'd1;
        end
        push(0, 1);
        push(6, 1);
        drain();
        chk_v("grant count", 16'h0002, 16'(grantSlots.size()));
        chk_v("first slot", 16'h0000, 16'(grantSlots[0]));
        chk_v("second slot", 16'h0006, 16'(grantSlots[1]));
    endtask
    task automatic t_burst();
        syncInBurst = 0;
        @(negedge clock) words[3] = 6'd4;
        push(3, 4);
        drain();
        chk_v("sync during burst", 0, 16'(syncInBurst));
    endtask
    // memory stalled: fifo fills, grants must stop
    task automatic t_full();
        ackHold = 1'b1;
        grantCnt = 0;
        @(negedge clock) words[7] = 6'd40;
        push(7, 40);
        repeat (4000) @(negedge clock);
        chk_v("grants while full", 16'(FIFO_DEPTH), 16'(grantCnt));
        ackHold = 1'b0;
        ackWait = 5;
        drain();
    endtask

    initial begin
        sys_rst = 1'b1;
        words = '0;
        ackHold = 1'b0;
        repeat (16) @(posedge clock);
        @(negedge clock) sys_rst = 1'b0;
        repeat (2) @(negedge clock);
        chk_v("chain enable", 1, chainEnOut);
        t_single();
        t_priority();
        t_burst();
        t_full();
        stop_test();
    end
    // whole run needs about 5k cycles
    initial begin
        repeat (60000) @(posedge clock);
        miscompares++;
        $display("MISMATCH watchdog expected done seen hang");
        stop_test();
    end
endmodule
